// ===== core/ectu_top.sv
// encoder counters, trigger gating and measurement cycle with apb registers
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module ectu_top #(
	parameter logic [8:0] RATE_MAX = 9'(ectu_pkg::RATE_MAX_STD) // rate ceiling
) (
	input wire logic CLK, // unit clock, 25 MHz
	input wire logic NRST, // async reset, low
	input wire logic PSEL, // apb select
	input wire logic PENABLE, // apb access phase
	input wire logic PWRITE, // apb direction
	input wire logic [7:0] PADDR, // apb byte address
	input wire logic [31:0] PWDATA, // apb write data
	output logic [31:0] PRDATA, // apb read data
	output logic PREADY, // apb ready
	output logic PSLVERR, // apb error
	input wire logic [2:0] ENC_A, // encoder track a pins
	input wire logic [2:0] ENC_B, // encoder track b pins
	input wire logic [2:0] ENC_Z, // encoder reference pins
	input wire logic SYNC_TRIG, // sync/trigger pin
	input wire logic EXTERNAL_TRIGGER_INPUT, // second trigger pin
	input wire logic EXPO_START, // exposure start pulse
	input wire logic [23:0] EXPO_HALF, // half exposure length, cycles
	output logic CYCLE_PULSE, // measurement cycle strobe
	output logic OUT_VALID, // record valid pulse
	output ectu_pkg::ectu_rec_t OUT_REC // recorded value stamp
);
	localparam int N = ectu_pkg::ENC_NUM;
	logic [6:0] ctrl_reg;
	logic [8:0] rate_reg;
	logic [31:0] trcnt_reg, trlo_reg, trhi_reg, trstep_reg;
	ectu_pkg::ectu_enc_cfg_t cfg_reg [N];
	logic [N-1:0][31:0] count;
	logic [N-1:0][31:0] snap_reg;
	logic [N-1:0] ref_seen;
	logic [3*N+1:0] pins_s;
	logic wr, wr_ctrl, sw_cmd, clr_seq;
	logic [N-1:0] load_cmd, rearm_cmd;
	logic [7:0] enc_off;
	logic enc_hit;
	logic [1:0] enc_idx;
	logic [25:0] acc_reg, acc_sum;
	logic cyc;
	logic trig_pin, lvl_act, lvl_prev_reg, edge_evt, evt;
	logic pend_reg, run_reg, rec_now, enc_fire;
	logic [31:0] rem_reg, tgt_reg, ecnt, seq_reg;
	logic [23:0] expo_cnt_reg, half_reg;
	logic expo_run_reg, mid_hit;
	logic [31:0] rd_data;
	logic rd_err;
	ectu_pkg::ectu_trig_mode_t mode;

	// clamp a rate setting into the legal step range
	function automatic logic [8:0] clamp_rate(input logic [31:0] v);
		if (v < 32'(ectu_pkg::RATE_MIN_STEPS))
			return ectu_pkg::RATE_MIN_STEPS;
		if (v > 32'(RATE_MAX))
			return RATE_MAX;
		return v[8:0];
	endfunction

	// pins through two flops before any use
	ectu_sync #(.W(3 * N + 2)) u_sync (
		.clk(CLK),
		.nrst(NRST),
		.d({ENC_Z, ENC_B, ENC_A, EXTERNAL_TRIGGER_INPUT, SYNC_TRIG}),
		.q(pins_s)
	);

	// three independent counters
	for (genvar i = 0; i < N; i++)
	begin : g_enc
		ectu_quad_counter u_cnt (
			.clk(CLK),
			.nrst(NRST),
			.a(pins_s[2 + i]),
			.b(pins_s[2 + N + i]),
			.z(pins_s[2 + 2 * N + i]),
			.load(load_cmd[i]),
			.rearm(rearm_cmd[i]),
			.cfg(cfg_reg[i]),
			.count(count[i]),
			.ref_seen(ref_seen[i])
		);
	end

	// apb decode and command pulses
	always_comb
	begin
		wr = PSEL & PENABLE & PWRITE;
		wr_ctrl = wr && PADDR == ectu_pkg::OFS_CTRL;
		enc_hit = PADDR >= ectu_pkg::OFS_ENC_BASE
			&& PADDR < ectu_pkg::OFS_ENC_END;
		enc_off = PADDR - ectu_pkg::OFS_ENC_BASE;
		enc_idx = enc_off[5:4];
		sw_cmd = wr && PADDR == ectu_pkg::OFS_CMD
			&& PWDATA[ectu_pkg::CMD_SW_BIT];
		clr_seq = wr && PADDR == ectu_pkg::OFS_CMD
			&& PWDATA[ectu_pkg::CMD_CLRSEQ_BIT];
		load_cmd = (wr && PADDR == ectu_pkg::OFS_CMD)
			? PWDATA[ectu_pkg::CMD_LOAD_LSB +: N] : '0;
		rearm_cmd = (wr && PADDR == ectu_pkg::OFS_CMD)
			? PWDATA[ectu_pkg::CMD_REARM_LSB +: N] : '0;
	end

	// trigger and rate configuration registers
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			ctrl_reg <= ectu_pkg::CTRL_RST;
			rate_reg <= ectu_pkg::RATE_RST;
			trcnt_reg <= ectu_pkg::TRCNT_RST;
			trlo_reg <= '0;
			trhi_reg <= '0;
			trstep_reg <= '0;
		end
		else if (wr)
		begin
			unique case (PADDR)
				ectu_pkg::OFS_CTRL: ctrl_reg <= PWDATA[6:0];
				ectu_pkg::OFS_RATE: rate_reg <= clamp_rate(PWDATA);
				ectu_pkg::OFS_TRCNT: trcnt_reg <= PWDATA;
				ectu_pkg::OFS_TRLO: trlo_reg <= PWDATA;
				ectu_pkg::OFS_TRHI: trhi_reg <= PWDATA;
				ectu_pkg::OFS_TRSTEP: trstep_reg <= PWDATA;
				default: ;
			endcase
		end
	end

	// encoder configuration registers
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			for (int i = 0; i < N; i++)
			begin
				cfg_reg[i] <= {ectu_pkg::IP_X1, ectu_pkg::RM_NONE,
					ectu_pkg::MAX_RST, ectu_pkg::PRESET_RST};
			end
		end
		else if (wr && enc_hit)
		begin
			unique case (enc_off[3:0])
				ectu_pkg::ENC_CFG:
				begin
					cfg_reg[enc_idx].interp <= ectu_pkg::ectu_interp_t'(PWDATA[1:0]);
					cfg_reg[enc_idx].ref_mode <= ectu_pkg::ectu_ref_t'(PWDATA[3:2]);
				end
				ectu_pkg::ENC_MAX: cfg_reg[enc_idx].max <= PWDATA;
				ectu_pkg::ENC_PRESET: cfg_reg[enc_idx].preset <= PWDATA;
				default: ;
			endcase
		end
	end

	// read mux and error for unmapped or misaligned words
	always_comb
	begin
		rd_data = '0;
		rd_err = PADDR[1:0] != 2'b00;
		if (enc_hit)
		begin
			unique case (enc_off[3:0])
				ectu_pkg::ENC_CFG: rd_data = {28'h000_0000,
					cfg_reg[enc_idx].ref_mode, cfg_reg[enc_idx].interp};
				ectu_pkg::ENC_MAX: rd_data = cfg_reg[enc_idx].max;
				ectu_pkg::ENC_PRESET: rd_data = cfg_reg[enc_idx].preset;
				ectu_pkg::ENC_COUNT: rd_data = count[enc_idx];
				default: rd_err = 1'b1;
			endcase
		end
		else
		begin
			unique case (PADDR)
				ectu_pkg::OFS_CTRL: rd_data = {25'h000_0000, ctrl_reg};
				ectu_pkg::OFS_RATE: rd_data = {23'h00_0000, rate_reg};
				ectu_pkg::OFS_TRCNT: rd_data = trcnt_reg;
				ectu_pkg::OFS_TRLO: rd_data = trlo_reg;
				ectu_pkg::OFS_TRHI: rd_data = trhi_reg;
				ectu_pkg::OFS_TRSTEP: rd_data = trstep_reg;
				ectu_pkg::OFS_CMD: rd_data = '0;
				ectu_pkg::OFS_STATUS: rd_data = {27'h000_0000, pend_reg,
					run_reg | (rem_reg != '0), ref_seen};
				ectu_pkg::OFS_SEQ: rd_data = seq_reg;
				default: rd_err = 1'b1;
			endcase
		end
	end

	// read data and error captured in the setup cycle
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			PRDATA <= '0;
			PSLVERR <= 1'b0;
		end
		else if (PSEL && !PENABLE)
		begin
			PRDATA <= PWRITE ? '0 : rd_data;
			PSLVERR <= rd_err;
		end
	end
	assign PREADY = 1'b1;

	// measurement cycle from a phase accumulator, one for all channels
	assign acc_sum = acc_reg + 26'(rate_reg) * 26'(ectu_pkg::RATE_STEP_HZ);
	assign cyc = acc_sum >= ectu_pkg::CLK_HZ_W;
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
			acc_reg <= '0;
		else
			acc_reg <= cyc ? acc_sum - ectu_pkg::CLK_HZ_W : acc_sum;
	end
	assign CYCLE_PULSE = cyc;

	// exposure midpoint capture of all counters
	assign mid_hit = expo_run_reg && expo_cnt_reg == half_reg;
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			expo_run_reg <= 1'b0;
			expo_cnt_reg <= '0;
			half_reg <= '0;
			snap_reg <= '0;
		end
		else
		begin
			if (EXPO_START)
			begin
				expo_run_reg <= 1'b1;
				expo_cnt_reg <= '0;
				half_reg <= EXPO_HALF;
			end
			else if (mid_hit)
				expo_run_reg <= 1'b0;
			else if (expo_run_reg)
				expo_cnt_reg <= expo_cnt_reg + 1'b1;
			if (mid_hit)
				snap_reg <= count;
		end
	end

	// trigger source, level and edge detection
	always_comb
	begin
		mode = ectu_pkg::ectu_trig_mode_t'(ctrl_reg[2:0]);
		trig_pin = ctrl_reg[ectu_pkg::CTRL_SRC_BIT] ? pins_s[1] : pins_s[0];
		lvl_act = ctrl_reg[ectu_pkg::CTRL_POL_BIT] ? trig_pin : ~trig_pin;
		edge_evt = lvl_act & ~lvl_prev_reg;
		ecnt = ctrl_reg[ectu_pkg::CTRL_ESEL_BIT] ? count[1] : count[0];
		enc_fire = mode == ectu_pkg::TM_ENC && ecnt == tgt_reg
			&& tgt_reg <= trhi_reg;
		unique case (mode)
			ectu_pkg::TM_EDGE: evt = edge_evt;
			ectu_pkg::TM_SW: evt = sw_cmd;
			ectu_pkg::TM_ENC: evt = enc_fire;
			default: evt = 1'b0;
		endcase
	end

	// decide at the cycle boundary whether this cycle is recorded
	always_comb
	begin
		unique case (mode)
			ectu_pkg::TM_OFF: rec_now = 1'b1;
			ectu_pkg::TM_LEVEL: rec_now = lvl_act;
			ectu_pkg::TM_EDGE, ectu_pkg::TM_SW: rec_now = run_reg
				|| rem_reg != '0 || (pend_reg && (trcnt_reg != '0
				|| ctrl_reg[ectu_pkg::CTRL_INF_BIT]));
			ectu_pkg::TM_ENC: rec_now = pend_reg;
			default: rec_now = 1'b0;
		endcase
	end

	// pending trigger, run state and encoder target
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			lvl_prev_reg <= 1'b0;
			pend_reg <= 1'b0;
			run_reg <= 1'b0;
			rem_reg <= '0;
			tgt_reg <= '0;
		end
		else
		begin
			lvl_prev_reg <= lvl_act;
			if (evt)
				pend_reg <= 1'b1;
			else if (cyc || wr_ctrl)
				pend_reg <= 1'b0;
			if (wr_ctrl)
			begin
				run_reg <= 1'b0;
				rem_reg <= '0;
			end
			else if (cyc && pend_reg && ctrl_reg[ectu_pkg::CTRL_INF_BIT])
				run_reg <= 1'b1;
			else if (cyc && pend_reg && trcnt_reg != '0)
				rem_reg <= trcnt_reg - 1'b1;
			else if (cyc && rem_reg != '0)
				rem_reg <= rem_reg - 1'b1;
			if (wr_ctrl)
				tgt_reg <= trlo_reg;
			else if (enc_fire && trstep_reg != '0)
				tgt_reg <= tgt_reg + trstep_reg;
		end
	end

	// record output and sequence counter
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			OUT_VALID <= 1'b0;
			OUT_REC <= '0;
			seq_reg <= '0;
		end
		else
		begin
			OUT_VALID <= cyc & rec_now;
			if (cyc && rec_now)
			begin
				OUT_REC.seq <= seq_reg;
				OUT_REC.enc <= snap_reg;
			end
			if (clr_seq)
				seq_reg <= {31'h0000_0000, cyc & rec_now};
			else if (cyc && rec_now)
				seq_reg <= seq_reg + 1'b1;
		end
	end

	sequence sw_req_s;
		mode == ectu_pkg::TM_SW && sw_cmd;
	endsequence
	sequence boundary_s;
		cyc && pend_reg;
	endsequence

	seq_step_a: assert property (@(posedge CLK) disable iff (!NRST)
		cyc && rec_now && !clr_seq |=> OUT_VALID && OUT_REC.seq
		== $past(seq_reg) && seq_reg == $past(seq_reg) + 1)
		else $error("sequence counter did not advance");
	cont_output_a: assert property (@(posedge CLK) disable iff (!NRST)
		cyc && mode == ectu_pkg::TM_OFF |=> OUT_VALID)
		else $error("no output with triggering off");
	gate_rate_a: assert property (@(posedge CLK) disable iff (!NRST)
		OUT_VALID |-> $past(cyc))
		else $error("output outside a measurement cycle");
	level_stop_a: assert property (@(posedge CLK) disable iff (!NRST)
		cyc && mode == ectu_pkg::TM_LEVEL |=> OUT_VALID == $past(lvl_act))
		else $error("level gating wrong");
	sw_start_a: assert property (@(posedge CLK) disable iff (!NRST)
		sw_req_s |=> pend_reg)
		else $error("software trigger not taken");
	edge_count_a: assert property (@(posedge CLK) disable iff (!NRST)
		boundary_s ##0 (mode == ectu_pkg::TM_EDGE && !wr_ctrl && trcnt_reg
		!= '0 && !ctrl_reg[ectu_pkg::CTRL_INF_BIT])
		|=> OUT_VALID && rem_reg == $past(trcnt_reg) - 1)
		else $error("edge trigger count not loaded");
	mid_snap_a: assert property (@(posedge CLK) disable iff (!NRST)
		mid_hit |=> snap_reg == $past(count) && !expo_run_reg)
		else $error("midpoint snapshot missed");
	enc_step_a: assert property (@(posedge CLK) disable iff (!NRST)
		enc_fire && !wr_ctrl |=> tgt_reg == $past(tgt_reg) + $past(trstep_reg)
		&& pend_reg)
		else $error("encoder target did not step");
	rate_range_a: assert property (@(posedge CLK) disable iff (!NRST)
		rate_reg >= ectu_pkg::RATE_MIN_STEPS && rate_reg <= RATE_MAX)
		else $error("rate setting out of range");
endmodule

// ===== shared/ectu_pkg.sv
// constants, field layout and carrier types of the encoder counter unit
package ectu_pkg;
	// clock and measuring-rate timing
	localparam int CLK_HZ = 25_000_000;
	localparam logic [25:0] CLK_HZ_W = 26'h17d_7840;
	localparam int RATE_STEP_HZ = 100;
	localparam logic [8:0] RATE_MIN_STEPS = 9'h001;
	localparam int RATE_MAX_STD = 65;
	localparam int RATE_MAX_FAST = 300;
	localparam logic [8:0] RATE_RST = 9'h00a;
	localparam int ENC_NUM = 3;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RATE = 8'h04;
	localparam logic [7:0] OFS_TRCNT = 8'h08;
	localparam logic [7:0] OFS_TRLO = 8'h0c;
	localparam logic [7:0] OFS_TRHI = 8'h10;
	localparam logic [7:0] OFS_TRSTEP = 8'h14;
	localparam logic [7:0] OFS_CMD = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	localparam logic [7:0] OFS_ENC_BASE = 8'h20;
	localparam logic [7:0] OFS_ENC_END = 8'h50;
	localparam logic [7:0] OFS_SEQ = 8'h50;
	localparam logic [3:0] ENC_CFG = 4'h0;
	localparam logic [3:0] ENC_MAX = 4'h4;
	localparam logic [3:0] ENC_PRESET = 4'h8;
	localparam logic [3:0] ENC_COUNT = 4'hc;
	// field positions
	localparam int CTRL_SRC_BIT = 3;
	localparam int CTRL_POL_BIT = 4;
	localparam int CTRL_INF_BIT = 5;
	localparam int CTRL_ESEL_BIT = 6;
	localparam int CMD_SW_BIT = 0;
	localparam int CMD_CLRSEQ_BIT = 1;
	localparam int CMD_LOAD_LSB = 2;
	localparam int CMD_REARM_LSB = 5;
	// reset values
	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam logic [31:0] TRCNT_RST = 32'h0000_0001;
	localparam logic [31:0] MAX_RST = 32'hffff_ffff;
	localparam logic [31:0] PRESET_RST = 32'h0000_0000;
	// modes
	typedef enum logic [2:0] {TM_OFF, TM_LEVEL, TM_EDGE, TM_SW, TM_ENC}
		ectu_trig_mode_t;
	typedef enum logic [1:0] {IP_X1, IP_X2, IP_X4} ectu_interp_t;
	typedef enum logic [1:0] {RM_NONE, RM_FIRST, RM_EVERY} ectu_ref_t;
	// per-encoder configuration
	typedef struct packed {
		ectu_interp_t interp;
		ectu_ref_t ref_mode;
		logic [31:0] max;
		logic [31:0] preset;
	} ectu_enc_cfg_t;
	// one output record
	typedef struct packed {
		logic [31:0] seq;
		logic [ENC_NUM-1:0][31:0] enc;
	} ectu_rec_t;
endpackage

// ===== core/ectu_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module ectu_sync #(
	parameter int W = 1
) (
	input wire logic clk, // unit clock
	input wire logic nrst, // async reset, low
	input wire logic [W-1:0] d, // asynchronous inputs
	output logic [W-1:0] q // synchronised outputs
);
	logic [W-1:0] meta_reg;
	// two stages, first read only by second
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_reg <= '0;
			q <= '0;
		end
		else
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// ===== core/ectu_quad_counter.sv
// quadrature counter with interpolation, wrap, preset and reference
`timescale 1ns/10ps
module ectu_quad_counter (
	input wire logic clk, // unit clock
	input wire logic nrst, // async reset, low
	input wire logic a, // track a, synchronised
	input wire logic b, // track b, synchronised
	input wire logic z, // reference track, synchronised
	input wire logic load, // preset-load command pulse
	input wire logic rearm, // reset-reference command pulse
	input ectu_pkg::ectu_enc_cfg_t cfg, // configuration
	output logic [31:0] count, // counter value
	output logic ref_seen // reference mark recorded
);
	logic a_reg, b_reg, z_reg, init_reg, ref_reg;
	logic [31:0] count_reg, count_next;
	logic step, up, mark, do_load;

	// edge qualification and direction
	always_comb
	begin
		up = (a ^ a_reg) ? (a != b) : (a == b);
		unique case (cfg.interp)
			ectu_pkg::IP_X1: step = (a ^ a_reg) & a;
			ectu_pkg::IP_X2: step = a ^ a_reg;
			ectu_pkg::IP_X4: step = (a ^ a_reg) | (b ^ b_reg);
			default: step = 1'b0;
		endcase
		mark = z & ~z_reg;
		do_load = init_reg | load
			| (mark & (cfg.ref_mode == ectu_pkg::RM_EVERY))
			| (mark & (cfg.ref_mode == ectu_pkg::RM_FIRST) & ~ref_reg);
	end

	// next count: preset first, then wrapping count
	always_comb
	begin
		count_next = count_reg;
		if (do_load)
			count_next = cfg.preset;
		else if (step && up)
			count_next = (count_reg >= cfg.max) ? '0 : count_reg + 1'b1;
		else if (step)
			count_next = (count_reg == '0) ? cfg.max : count_reg - 1'b1;
	end

	// input history, counter and power-on load
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			a_reg <= 1'b0;
			b_reg <= 1'b0;
			z_reg <= 1'b0;
			init_reg <= 1'b1;
			count_reg <= '0;
		end
		else
		begin
			a_reg <= a;
			b_reg <= b;
			z_reg <= z;
			init_reg <= 1'b0;
			count_reg <= count_next;
		end
	end

	// mark record, detection wins over re-arm
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ref_reg <= 1'b0;
		else if (mark && cfg.ref_mode != ectu_pkg::RM_NONE)
			ref_reg <= 1'b1;
		else if (rearm)
			ref_reg <= 1'b0;
	end

	assign count = count_reg;
	assign ref_seen = ref_reg;

	sequence up_step_s;
		step && up && !do_load;
	endsequence

	wrap_zero_a: assert property (@(posedge clk) disable iff (!nrst)
		up_step_s ##0 (count_reg >= cfg.max) |=> count_reg == 32'h0000_0000)
		else $error("counter did not wrap to zero");
	count_up_a: assert property (@(posedge clk) disable iff (!nrst)
		up_step_s ##0 (count_reg < cfg.max) |=> count_reg == $past(count_reg) + 1)
		else $error("counter did not count up");
	first_once_a: assert property (@(posedge clk) disable iff (!nrst)
		mark && ref_reg && cfg.ref_mode == ectu_pkg::RM_FIRST && !load
		&& !init_reg && !step |=> count_reg == $past(count_reg))
		else $error("first-mark mode loaded a second time");
	every_mark_a: assert property (@(posedge clk) disable iff (!nrst)
		mark && cfg.ref_mode == ectu_pkg::RM_EVERY |=> count_reg == $past(cfg.preset))
		else $error("mark did not load preset");
	no_ref_a: assert property (@(posedge clk) disable iff (!nrst)
		cfg.ref_mode == ectu_pkg::RM_NONE && !step && !load && !init_reg
		|=> count_reg == $past(count_reg))
		else $error("counter changed without cause");
	power_load_a: assert property (@(posedge clk) disable iff (!nrst)
		init_reg |=> count_reg == $past(cfg.preset))
		else $error("preset not loaded after reset");
endmodule

// ===== tb/ectu_far_model.sv
// quadrature encoders and external trigger source facing the unit's pins
`timescale 1ns/10ps
module ectu_far_model (
	input wire logic clk, // unit clock
	input wire logic [2:0] up, // one edge forward per encoder
	input wire logic [2:0] dn, // one edge back per encoder
	input wire logic [2:0] mark, // reference mark level
	input wire logic [1:0] hold, // trigger request per pin
	output logic [2:0] enc_a, // track a
	output logic [2:0] enc_b, // track b
	output logic [2:0] enc_z, // reference track
	output logic [1:0] trig // trigger pins, idle low
);
	logic [1:0] ph [3] = '{2'h0, 2'h0, 2'h0};
	logic [7:0] len [2] = '{8'h00, 8'h00};
	// phase index, up adds one and down takes one
	always @(posedge clk)
		for (int i = 0; i < 3; i++)
			ph[i] <= ph[i] + {dn[i], up[i] | dn[i]};
	// gray order 00 10 11 01, a leads b when moving up
	always_comb
		for (int i = 0; i < 3; i++)
		begin
			enc_a[i] = ph[i][1] ^ ph[i][0];
			enc_b[i] = ph[i][1];
		end
	assign enc_z = mark;
	// each request stretched past 5 us, level and pause over a cycle
	always @(posedge clk)
		for (int k = 0; k < 2; k++)
			len[k] <= hold[k] ? 8'h82 : len[k] - 8'(len[k] != 8'h00);
	// pin high while requested or stretched
	always_comb
		for (int k = 0; k < 2; k++)
			trig[k] = hold[k] | (len[k] != 8'h00);
endmodule

// ===== tb/tb_encoder_counter_trigger_unit.sv
// self-checking bench for the encoder counter and trigger unit
`timescale 1ns/10ps
module tb_encoder_counter_trigger_unit;
	localparam logic [7:0] CT = ectu_pkg::OFS_CTRL;
	localparam logic [7:0] TC = ectu_pkg::OFS_TRCNT;
	localparam logic [7:0] CM = ectu_pkg::OFS_CMD;
	localparam logic [7:0] ST = ectu_pkg::OFS_STATUS;
	logic CLK = 1'b0;
	logic NRST = 1'b0;
	logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, EXPO_START = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0000_0000;
	logic [23:0] EXPO_HALF = 24'h00_000a;
	logic [31:0] PRDATA, q;
	logic PREADY, PSLVERR, CYCLE_PULSE, OUT_VALID, e;
	logic [2:0] ENC_A, ENC_B, ENC_Z;
	logic [2:0] up = 3'h0, dn = 3'h0, mark = 3'h0;
	logic [1:0] hold = 2'h0, trig;
	ectu_pkg::ectu_rec_t OUT_REC, rec;
	int err_count = 0, comparisons = 0, rec_n = 0, cyc_n = 0, r0, c0;
	// 25 MHz unit clock
	initial
		forever #20 CLK = ~CLK;
	ectu_top dut_u (.CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
		.PRDATA, .PREADY, .PSLVERR, .ENC_A, .ENC_B, .ENC_Z,
		.SYNC_TRIG(trig[0]), .EXTERNAL_TRIGGER_INPUT(trig[1]), .EXPO_START,
		.EXPO_HALF, .CYCLE_PULSE, .OUT_VALID, .OUT_REC);
	ectu_far_model far_u (.clk(CLK), .up, .dn, .mark, .hold, .enc_a(ENC_A),
		.enc_b(ENC_B), .enc_z(ENC_Z), .trig);
	// counts cycle strobes and records
	always @(posedge CLK)
	begin
		cyc_n <= cyc_n + int'(CYCLE_PULSE === 1'b1);
		rec_n <= rec_n + int'(OUT_VALID === 1'b1);
	end
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer, held until pready at a rising edge
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do
			@(posedge CLK);
		while (PREADY !== 1'b1);
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(string nm, logic [7:0] a, logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		check(nm, q, x);
	endtask
	function automatic logic [7:0] ea(int i, logic [3:0] o);
		return ectu_pkg::OFS_ENC_BASE + 8'(16 * i) + 8'(o);
	endfunction
	task automatic rc(int i, logic [31:0] x);
		rd("count", ea(i, ectu_pkg::ENC_COUNT), x);
	endtask
	task automatic idle(int n);
		repeat (n) @(posedge CLK);
	endtask
	task automatic step(int i, int n, logic fwd);
		repeat (n)
		begin
			up[i] <= fwd;
			dn[i] <= ~fwd;
			@(posedge CLK);
			up[i] <= 1'b0;
			dn[i] <= 1'b0;
			idle(4);
		end
		idle(4);
	endtask
	task automatic mk(int i);
		mark[i] <= 1'b1;
		idle(4);
		mark[i] <= 1'b0;
		idle(6);
	endtask
	task automatic wait_rec;
		do
			@(negedge CLK);
		while (OUT_VALID !== 1'b1);
		rec = OUT_REC;
		@(posedge CLK);
	endtask
	task automatic pulse(int k);
		hold[k] <= 1'b1;
		@(posedge CLK);
		hold[k] <= 1'b0;
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// cuts a hang short
	initial
	begin
		idle(100000);
		err_count++;
		end_sim();
	end
	// main sequence
	initial
	begin
		idle(5);
		NRST <= 1'b1;
		@(posedge CLK);
		rd("trcnt", TC, ectu_pkg::TRCNT_RST);
		rd("max", ea(0, ectu_pkg::ENC_MAX), ectu_pkg::MAX_RST);
		rc(0, ectu_pkg::PRESET_RST);
		apb(1'b0, 8'h54, 32'h0000_0000);
		check("slverr", 32'(e), 32'h0000_0001);
		wr(ectu_pkg::OFS_RATE, 32'h0000_0190);
		rd("rate", ectu_pkg::OFS_RATE, 32'h0000_0041);
		wait_rec();
		check("seq", rec.seq, 32'h0000_0000);
		wait_rec();
		check("seq", rec.seq, 32'h0000_0001);
		step(0, 4, 1'b1);
		rc(0, 32'h0000_0001);
		wr(ea(0, 4'h0), 32'h0000_0002);
		step(0, 3, 1'b1);
		step(0, 2, 1'b0);
		rc(0, 32'h0000_0002);
		wr(ea(0, 4'h0), 32'h0000_0001);
		step(0, 4, 1'b1);
		rc(0, 32'h0000_0004);
		wr(ea(1, 4'h0), 32'h0000_0002);
		wr(ea(1, 4'h4), 32'h0000_0005);
		step(1, 1, 1'b0);
		rc(1, 32'h0000_0005);
		step(1, 1, 1'b1);
		rc(1, 32'h0000_0000);
		wr(ea(1, 4'h8), 32'h0000_0003);
		wr(CM, 32'h0000_0008);
		rc(1, 32'h0000_0003);
		mk(1);
		rc(1, 32'h0000_0003);
		wr(ea(2, 4'h0), 32'h0000_0006);
		wr(ea(2, 4'h8), 32'h0000_0009);
		step(2, 2, 1'b1);
		mk(2);
		rc(2, 32'h0000_0009);
		step(2, 1, 1'b1);
		mk(2);
		rc(2, 32'h0000_000a);
		wr(CM, 32'h0000_0080);
		apb(1'b0, ST, 32'h0000_0000);
		check("refseen", 32'(q[2]), 32'h0000_0000);
		mk(2);
		rc(2, 32'h0000_0009);
		wr(ea(1, 4'h0), 32'h0000_000a);
		step(1, 1, 1'b1);
		mk(1);
		step(1, 2, 1'b1);
		mk(1);
		rc(1, 32'h0000_0003);
		EXPO_START <= 1'b1;
		@(posedge CLK);
		EXPO_START <= 1'b0;
		idle(20);
		step(0, 4, 1'b1);
		wait_rec();
		check("snap0", rec.enc[0], 32'h0000_0004);
		check("snap1", rec.enc[1], 32'h0000_0003);
		check("snap2", rec.enc[2], 32'h0000_0009);
		wr(TC, 32'h0000_0003);
		wr(CT, 32'h0000_0003);
		idle(10);
		r0 = rec_n;
		c0 = cyc_n;
		idle(2000);
		check("idle", 32'(rec_n - r0), 32'h0000_0000);
		wr(CM, 32'h0000_0001);
		idle(16000);
		check("sw", 32'(rec_n - r0), 32'h0000_0003);
		check("rate", 32'(cyc_n - c0 inside {[4:5]}), 32'h0000_0001);
		wr(TC, 32'h0000_0002);
		wr(CT, 32'h0000_0012);
		r0 = rec_n;
		pulse(0);
		idle(12500);
		check("edge", 32'(rec_n - r0), 32'h0000_0002);
		wr(CT, 32'h0000_003a);
		r0 = rec_n;
		pulse(1);
		idle(9000);
		check("inf", 32'(rec_n - r0 >= 2), 32'h0000_0001);
		wr(CT, 32'h0000_0011);
		r0 = rec_n;
		hold[0] <= 1'b1;
		idle(11600);
		hold[0] <= 1'b0;
		check("lvl", 32'(rec_n - r0 inside {[3:4]}), 32'h0000_0001);
		// let the stretched pin fall and any record in flight land
		idle(200);
		r0 = rec_n;
		idle(4000);
		check("lvloff", 32'(rec_n - r0), 32'h0000_0000);
		wr(ea(1, 4'h4), 32'hffff_ffff);
		wr(ectu_pkg::OFS_TRLO, 32'h0000_0005);
		wr(ectu_pkg::OFS_TRHI, 32'h0000_0007);
		wr(ectu_pkg::OFS_TRSTEP, 32'h0000_0002);
		wr(CT, 32'h0000_0044);
		r0 = rec_n;
		repeat (3)
		begin
			step(1, 2, 1'b1);
			idle(4000);
		end
		check("enc", 32'(rec_n - r0), 32'h0000_0002);
		// clear sequence and load counter 0, then one falling-edge trigger
		wr(CM, 32'h0000_0006);
		rd("seqclr", ectu_pkg::OFS_SEQ, 32'h0000_0000);
		rc(0, ectu_pkg::PRESET_RST);
		wr(TC, 32'h0000_0001);
		wr(CT, 32'h0000_0002);
		r0 = rec_n;
		pulse(0);
		idle(4200);
		check("fall", 32'(rec_n - r0), 32'h0000_0001);
		rd("seq", ectu_pkg::OFS_SEQ, 32'h0000_0001);
		end_sim();
	end
endmodule
